// ---- design/hcl_pkg.sv ----
// Constants shared by the download-port device end and its host end.
// Assumes both ends run on one 10 MHz clock domain each.
`default_nettype none
package hcl_pkg;
   // Timing
   localparam int          CLK_PERIOD_NS    = 100;
   localparam int          LINK_PERIOD_NS   = 800;
   localparam int          LINK_HALF_CYC    = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   // Device subaddresses
   localparam logic [6:0]  SUB_CFG          = 7'h00;
   localparam logic [6:0]  SUB_STAT         = 7'h02;
   localparam logic [6:0]  SUB_HDR          = 7'h04;
   localparam logic [6:0]  SUB_DATA         = 7'h05;
   // Port configuration layout
   localparam logic [31:0] CFG_RESET        = 32'h00000000;
   localparam int          CFG_CLK_MST_BIT  = 24;
   localparam int          CFG_NORM_BIT     = 16;
   localparam int          CFG_OUT_WS_LSB   = 12;
   localparam int          CFG_IN_WS_LSB    = 8;
   localparam int          CFG_OUT_FMT_LSB  = 5;
   localparam int          CFG_IN_FMT_LSB   = 1;
   localparam logic [1:0]  WS_16            = 2'h0;
   localparam logic [1:0]  WS_20            = 2'h1;
   localparam logic [1:0]  WS_24            = 2'h2;
   localparam logic [4:0]  WS_16_BITS       = 5'h10;
   localparam logic [4:0]  WS_20_BITS       = 5'h14;
   localparam logic [4:0]  WS_24_BITS       = 5'h18;
   localparam logic [4:0]  WS_UNDEF_BITS    = 5'h00;
   localparam logic [1:0]  FMT_UNDEF        = 2'h3;
   // Status layout
   localparam int          ST_LOAD_LSB      = 32;
   localparam int          ST_CLR_MSB       = 40;
   localparam int          ST_BUSY_BIT      = 6;
   localparam int          ST_BUSERR_BIT    = 1;
   localparam int          ERR_INVALID_SEL  = 6;
   localparam int          ERR_END_HDR      = 7;
   localparam logic [7:0]  LOAD_ERR_NONE    = 8'h00;
   localparam logic [7:0]  LOAD_ERR_NO_CFG  = 8'hFF;
   // Memory select codes
   localparam logic [7:0]  MEM_SEL_LAST     = 8'h04;
   localparam logic [2:0]  MEM_CTRL_PROG    = 3'h0;
   // Embedded controller side of the bus error flag
   localparam logic [7:0]  EC_STAT_SFR      = 8'hC5;
   localparam logic [7:0]  EC_CLR_SFR       = 8'hC7;
   localparam int          EC_BUSERR_BIT    = 6;
   // Host APB map
   localparam logic [7:0]  HA_CTRL          = 8'h00;
   localparam logic [7:0]  HA_STATUS        = 8'h04;
   localparam logic [7:0]  HA_WD_HI         = 8'h08;
   localparam logic [7:0]  HA_WD_LO         = 8'h0C;
   localparam logic [7:0]  HA_RD_HI         = 8'h10;
   localparam logic [7:0]  HA_RD_LO         = 8'h14;
   localparam int          HC_READ_BIT      = 7;
   localparam int          HC_LEN_LSB       = 8;
   localparam int          HC_TERM_BIT      = 12;
   localparam logic [3:0]  HC_LEN_MAX       = 4'h8;
endpackage : hcl_pkg
`default_nettype wire

// ---- design/hcl_link_if.sv ----
// Serial control link between host and device.
// Host drives clock, frame and data out; device drives data back.
`default_nettype none
interface hcl_link_if;
   logic clk;
   logic frame_n;
   logic mosi;
   logic miso;
   modport dev  (input clk, input frame_n, input mosi, output miso);
   modport host (output clk, output frame_n, output mosi, input miso);
endinterface : hcl_link_if
`default_nettype wire

// ---- design/hcl_dev.sv ----
// Device end: port configuration, load status and slave download engine.
// Assumes the link pins come from another clock domain; they are resynchronised.
// Summary of operation
// - Clock role bit 24: 1 master, 0 slave
// - Bit 16 enables output normalization
// - Input size bits 9:8, output 13:12
// - Size codes 16, 20, 24 bits; 11 undefined
// - Format codes left, right, I2S; 11 undefined
// - Port configuration is four bytes long
// - Load failure sets bit, success clears it
// - Host writes zero to clear load errors
// - Load error bit layout 32 to 39
// - Field reports boot and host downloads
// - Bit 6 shows analog sequence busy
// - Bus error set; host zero write clears
// - Controller sees and clears bus error
// - Eight byte header then data register
// - Host sends header, data, then checksum
// - Controller program locked after first good-checksum load
// - Header sets error, valid checksum clears
// - Last two data bytes are checksum
// - Zero byte count header ends session
// - Memory select codes 0 to 4
// - Termination header fields all zero
//
// The implementer's own choice: register access over APB.
`default_nettype none
module hcl_dev (
   input  wire logic        pclk,
   input  wire logic        presetn,
   hcl_link_if.dev          link,
   input  wire logic        ext_cfg_present,
   input  wire logic        boot_done,
   input  wire logic [7:0]  boot_err,
   input  wire logic        analog_sequence_busy,
   input  wire logic        ec_bus_err_clr,
   output logic             ec_bus_err,
   output logic             clock_master_select,
   output logic             out_normalize,
   output logic [4:0]       in_word_bits,
   output logic [4:0]       out_word_bits,
   output logic [1:0]       in_format,
   output logic [1:0]       out_format,
   output logic             port_cfg_undefined,
   output logic             download_open,
   output logic             mem_wr_valid,
   output logic [2:0]       mem_wr_sel,
   output logic [15:0]      mem_wr_addr,
   output logic [7:0]       mem_wr_byte
);
   import hcl_pkg::*;

   typedef struct packed {
      logic [2:0]  s1;       // clk, frame_n, mosi first stage
      logic [2:0]  s2;
      logic [2:0]  hist;
      logic        pres1;
      logic        pres2;
      logic [1:0]  init_cnt;
      logic [2:0]  bit_cnt;
      logic [3:0]  byte_cnt;
      logic [6:0]  sh;
      logic        rd;
      logic [6:0]  sub;
      logic [63:0] acc;
      logic [63:0] out_sh;
      logic        miso;
      logic [31:0] cfg;
      logic [7:0]  lerr;
      logic        buserr;
      logic        open;
      logic        locked;
      logic        armed;
      logic        discard;
      logic [2:0]  mem;
      logic [15:0] addr;
      logic [15:0] left;
      logic [15:0] sum;
      logic [15:0] ck;
      logic        ckn;
      logic [7:0]  ckrx;
      logic        wv;
      logic [2:0]  wsel;
      logic [15:0] waddr;
      logic [7:0]  wbyte;
   } hcl_dev_s;

   localparam hcl_dev_s DEV_RESET = '{cfg: CFG_RESET, lerr: LOAD_ERR_NONE, s1: 3'h7,
                                      s2: 3'h7, hist: 3'h7, default: '0};

   hcl_dev_s    q;
   hcl_dev_s    d;
   logic        rise;
   logic        fstart;
   logic        fend;
   logic [7:0]  byte_in;
   logic [63:0] accw;
   logic [63:0] stat_word;
   logic [63:0] rd_word;
   logic [3:0]  idx;

   function automatic logic [4:0] ws_bits(input logic [1:0] code);
      case (code)
         WS_16:   ws_bits = WS_16_BITS;
         WS_20:   ws_bits = WS_20_BITS;
         WS_24:   ws_bits = WS_24_BITS;
         default: ws_bits = WS_UNDEF_BITS;
      endcase
   endfunction : ws_bits

   always_comb begin
      stat_word = '0;
      stat_word[ST_LOAD_LSB +: 8] = q.lerr;
      stat_word[ST_BUSY_BIT]      = analog_sequence_busy;
      stat_word[ST_BUSERR_BIT]    = q.buserr;
   end

   always_comb begin
      d       = q;
      d.wv    = 1'b0;
      d.s1    = {link.clk, link.frame_n, link.mosi};
      d.s2    = q.s1;
      d.hist  = q.s2;
      d.pres1 = ext_cfg_present;
      d.pres2 = q.pres1;
      rise    = q.s2[2] & ~q.hist[2];
      fstart  = ~q.s2[1] & q.hist[1];
      fend    = q.s2[1] & ~q.hist[1];
      byte_in = {q.sh, q.s2[0]};
      accw    = {q.acc[55:0], byte_in};
      idx     = q.byte_cnt - 4'h1;
      case (byte_in[6:0])
         SUB_CFG:  rd_word = {q.cfg, 32'h00000000};
         SUB_STAT: rd_word = stat_word;
         default:  rd_word = '0;
      endcase

      if (ec_bus_err_clr) begin
         d.buserr = 1'b0;
      end
      if (fstart) begin
         d.bit_cnt  = 3'h0;
         d.byte_cnt = 4'h0;
      end
      if (rise && !q.s2[1]) begin
         d.sh      = {q.sh[5:0], q.s2[0]};
         d.bit_cnt = q.bit_cnt + 3'h1;
         if (q.rd && q.byte_cnt != 4'h0) begin
            d.out_sh = {q.out_sh[62:0], 1'b0};
            d.miso   = q.out_sh[62];
         end
         if (q.bit_cnt == 3'h7) begin
            if (q.byte_cnt != 4'hF) begin
               d.byte_cnt = q.byte_cnt + 4'h1;
            end
            if (q.byte_cnt == 4'h0) begin
               d.rd     = byte_in[7];
               d.sub    = byte_in[6:0];
               d.out_sh = rd_word;
               d.miso   = rd_word[63];
               d.acc    = '0;
            end else if (!q.rd) begin
               d.acc = accw;
               case (q.sub)
                  SUB_CFG: begin
                     if (idx == 4'h3) begin
                        d.cfg = accw[31:0];
                     end
                  end
                  SUB_STAT: begin
                     if (idx == 4'h7) begin
                        if (accw[ST_CLR_MSB:ST_LOAD_LSB] == '0) begin
                           d.lerr = LOAD_ERR_NONE;
                        end
                        if (!accw[ST_BUSERR_BIT]) begin
                           d.buserr = 1'b0;
                        end
                     end
                  end
                  SUB_HDR: begin
                     if (idx == 4'h7) begin
                        d.armed = 1'b0;
                        if (accw[15:0] == 16'h0000) begin
                           d.open = 1'b0;
                        end else begin
                           d.open    = 1'b1;
                           d.armed   = 1'b1;
                           d.discard = 1'b0;
                           d.ckn     = 1'b0;
                           d.ck      = accw[63:48];
                           d.mem     = accw[42:40];
                           d.addr    = accw[31:16];
                           d.left    = accw[15:0];
                           d.sum     = {8'h00, accw[47:40]} + {8'h00, accw[39:32]}
                                     + {8'h00, accw[31:24]} + {8'h00, accw[23:16]}
                                     + {8'h00, accw[15:8]} + {8'h00, accw[7:0]};
                           if (accw[47:40] > MEM_SEL_LAST) begin
                              d.discard               = 1'b1;
                              d.lerr[ERR_INVALID_SEL] = 1'b1;
                           end else begin
                              d.lerr[accw[42:40]] = 1'b1;
                              if (accw[42:40] == MEM_CTRL_PROG && q.locked) begin
                                 d.discard = 1'b1;
                              end
                           end
                        end
                     end
                  end
                  SUB_DATA: begin
                     if (!q.armed) begin
                        // Data with no live header cannot be placed anywhere
                        d.lerr[ERR_END_HDR] = 1'b1;
                     end else if (q.left != 16'h0000) begin
                        d.left = q.left - 16'h0001;
                        d.addr = q.addr + 16'h0001;
                        d.sum  = q.sum + {8'h00, byte_in};
                        if (!q.discard) begin
                           d.wv    = 1'b1;
                           d.wsel  = q.mem;
                           d.waddr = q.addr;
                           d.wbyte = byte_in;
                        end
                     end else if (!q.ckn) begin
                        d.ckn  = 1'b1;
                        d.ckrx = byte_in;
                     end else begin
                        d.armed = 1'b0;
                        if (!q.discard) begin
                           if ({q.ckrx, byte_in} == q.ck) begin
                              d.lerr[q.mem] = 1'b0;
                              if (q.mem == MEM_CTRL_PROG) begin
                                 d.locked = 1'b1;
                              end
                           end else begin
                              d.lerr[q.mem] = 1'b1;
                           end
                        end
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
      end
      // Sets last so an event beats a clear in the same cycle
      if (fend && q.bit_cnt != 3'h0) begin
         d.buserr = 1'b1;
      end
      if (boot_done) begin
         d.lerr = boot_err;
      end
      if (q.init_cnt != 2'h3) begin
         d.init_cnt = q.init_cnt + 2'h1;
         if (q.init_cnt == 2'h2 && !q.pres2) begin
            d.lerr = LOAD_ERR_NO_CFG;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= DEV_RESET;
      end else begin
         q <= d;
      end
   end

   assign link.miso           = q.miso;
   assign clock_master_select = q.cfg[CFG_CLK_MST_BIT];
   assign out_normalize       = q.cfg[CFG_NORM_BIT];
   assign in_word_bits        = ws_bits(q.cfg[CFG_IN_WS_LSB +: 2]);
   assign out_word_bits       = ws_bits(q.cfg[CFG_OUT_WS_LSB +: 2]);
   assign in_format           = q.cfg[CFG_IN_FMT_LSB +: 2];
   assign out_format          = q.cfg[CFG_OUT_FMT_LSB +: 2];
   assign port_cfg_undefined  = (in_word_bits == WS_UNDEF_BITS)
                              | (out_word_bits == WS_UNDEF_BITS)
                              | (in_format == FMT_UNDEF) | (out_format == FMT_UNDEF);
   assign ec_bus_err          = q.buserr;
   assign download_open       = q.open;
   assign mem_wr_valid        = q.wv;
   assign mem_wr_sel          = q.wsel;
   assign mem_wr_addr         = q.waddr;
   assign mem_wr_byte         = q.wbyte;
endmodule : hcl_dev
`default_nettype wire

// ---- design/hcl_host.sv ----
// Host end: APB-programmed link master that writes and reads device registers.
// Assumes the device answers on miso one link clock after each rising edge.
`default_nettype none
module hcl_host (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   hcl_link_if.host         link
);
   import hcl_pkg::*;

   typedef enum logic [2:0] {H_IDLE, H_FRAME, H_HIGH, H_LOW, H_STOP, H_GAP} hcl_hst_e;

   typedef struct packed {
      hcl_hst_e    st;
      logic [2:0]  div;
      logic        lclk;
      logic        frm_n;
      logic        mosi;
      logic [6:0]  bit_idx;
      logic [6:0]  nbits;
      logic        rd;
      logic [71:0] tx;
      logic [63:0] rx;
      logic [63:0] wd;
      logic        m1;
      logic        m2;
   } hcl_host_s;

   localparam hcl_host_s HOST_RESET = '{st: H_IDLE, lclk: 1'b0, frm_n: 1'b1, default: '0};
   localparam logic [2:0] HALF_LAST = 3'(LINK_HALF_CYC - 1);

   hcl_host_s  q;
   hcl_host_s  d;
   logic       tick;
   logic       wr;
   logic       mapped;
   logic [3:0] len;

   always_comb begin
      d      = q;
      d.m1   = link.miso;
      d.m2   = q.m1;
      tick   = (q.div == HALF_LAST);
      wr     = psel & penable & pwrite;
      len    = pwdata[HC_LEN_LSB +: 4];
      d.div  = (q.st == H_IDLE || tick) ? 3'h0 : q.div + 3'h1;
      if (wr && paddr == HA_WD_HI) begin
         d.wd[63:32] = pwdata;
      end
      if (wr && paddr == HA_WD_LO) begin
         d.wd[31:0] = pwdata;
      end
      unique case (q.st)
         H_IDLE: begin
            if (wr && paddr == HA_CTRL) begin
               if (pwdata[HC_TERM_BIT]) begin
                  d.tx    = {1'b0, SUB_HDR, 64'h0};
                  d.nbits = 7'h48;
                  d.rd    = 1'b0;
                  d.st    = H_FRAME;
               end else if (len != 4'h0 && len <= HC_LEN_MAX) begin
                  // Software orders header, data and checksum itself
                  d.tx    = {pwdata[HC_READ_BIT], pwdata[6:0], q.wd};
                  d.nbits = {len + 4'h1, 3'h0};
                  d.rd    = pwdata[HC_READ_BIT];
                  d.st    = H_FRAME;
               end
               if (d.st == H_FRAME) begin
                  d.frm_n   = 1'b0;
                  d.mosi    = d.tx[71];
                  d.bit_idx = 7'h00;
                  d.rx      = '0;
               end
            end
         end
         H_FRAME: begin
            if (tick) begin
               d.lclk = 1'b1;
               d.st   = H_HIGH;
            end
         end
         H_HIGH: begin
            if (tick) begin
               d.lclk    = 1'b0;
               d.bit_idx = q.bit_idx + 7'h01;
               d.tx      = {q.tx[70:0], 1'b0};
               d.mosi    = q.tx[70];
               d.st      = (q.bit_idx + 7'h01 == q.nbits) ? H_STOP : H_LOW;
            end
         end
         H_LOW: begin
            if (tick) begin
               d.lclk = 1'b1;
               // Bit shown after the previous rise is stable here
               if (q.rd && q.bit_idx >= 7'h08) begin
                  d.rx = {q.rx[62:0], q.m2};
               end
               d.st = H_HIGH;
            end
         end
         H_STOP: begin
            if (tick) begin
               d.frm_n = 1'b1;
               d.mosi  = 1'b0;
               d.st    = H_GAP;
            end
         end
         H_GAP: begin
            if (tick) begin
               d.st = H_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= HOST_RESET;
      end else begin
         q <= d;
      end
   end

   always_comb begin
      mapped = 1'b1;
      case (paddr)
         HA_CTRL:   prdata = '0;
         HA_STATUS: prdata = {31'h00000000, q.st != H_IDLE};
         HA_WD_HI:  prdata = q.wd[63:32];
         HA_WD_LO:  prdata = q.wd[31:0];
         HA_RD_HI:  prdata = q.rx[63:32];
         HA_RD_LO:  prdata = q.rx[31:0];
         default: begin
            prdata = '0;
            mapped = 1'b0;
         end
      endcase
   end

   assign pready       = 1'b1;
   assign pslverr      = psel & penable & ~mapped;
   assign link.clk     = q.lclk;
   assign link.frame_n = q.frm_n;
   assign link.mosi    = q.mosi;
endmodule : hcl_host
`default_nettype wire

// ---- verification/hcl_chk.sv ----
// Checker for the link and download outputs of the host/device pair.
// Assumes one pclk domain; inputs are the joining link and device outputs.
`default_nettype none
module hcl_chk
   import hcl_pkg::*;
(
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       clk,
   input wire logic       frame_n,
   input wire logic       mosi,
   input wire logic       mem_wr_valid,
   input wire logic [2:0] mem_wr_sel,
   input wire logic       download_open,
   input wire logic [4:0] in_word_bits,
   input wire logic [4:0] out_word_bits,
   input wire logic [1:0] in_format,
   input wire logic [1:0] out_format,
   input wire logic       port_cfg_undefined,
   input wire logic       clock_master_select,
   input wire logic       out_normalize
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   clk_idle_a: assert property (frame_n |-> !clk)
      else $error("link clock outside frame");
   clk_half_a: assert property ($rose(clk) |-> clk [*4] ##1 !clk)
      else $error("link high phase not four cycles");
   mosi_hold_a: assert property (clk |-> $stable(mosi))
      else $error("data moved while link clock high");
   frame_lead_a: assert property ($fell(frame_n) |-> !clk [*4])
      else $error("frame lead too short");
   wr_pulse_a: assert property (mem_wr_valid |=> !mem_wr_valid)
      else $error("payload strobe longer than one cycle");
   wr_sel_a: assert property (mem_wr_valid |->
      mem_wr_sel <= 3'h4 && download_open)
      else $error("payload write with bad select or closed session");
   undef_flag_a: assert property (
      port_cfg_undefined == (in_word_bits == WS_UNDEF_BITS
      || out_word_bits == WS_UNDEF_BITS || in_format == FMT_UNDEF
      || out_format == FMT_UNDEF))
      else $error("undefined code flag wrong");
   cfg_frame_a: assert property (
      $changed({clock_master_select, out_normalize, in_format, out_format}) |-> !frame_n)
      else $error("configuration changed outside a frame");
   cover property ($rose(download_open));
   cover property ($fell(download_open));
   cover property (mem_wr_valid);
   cover property (port_cfg_undefined);
endmodule : hcl_chk
`default_nettype wire

// ---- verification/tb_top.sv ----
// Testbench: APB drives the host end, which talks to the device end.
// Assumes a second device on a bench-driven link for framing faults.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import hcl_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, chk_on, pe, pready, pslverr;
   logic        boot_done, abusy, ec_clr, cfg_pres, mcs, onorm, pcu, dopen, wv, be1, be2;
   logic [7:0]  paddr, boot_err, wbyte;
   logic [31:0] pwdata, prdata, r, v;
   logic [4:0]  iwb, owb;
   logic [1:0]  ifm, ofm;
   logic [2:0]  wsel;
   logic [15:0] waddr;
   logic [31:0] exp_q[$];
   logic [31:0] mem_q[$];
   int          num_errors = 0, tests_run = 0, cyc = 0, seed = 32'h0D776CF0;
   hcl_link_if l1();
   hcl_link_if l2();
   hcl_dev hcl_dev_i (.pclk(pclk), .presetn(presetn), .link(l1), .ext_cfg_present(cfg_pres),
      .boot_done(boot_done), .boot_err(boot_err), .analog_sequence_busy(abusy),
      .ec_bus_err_clr(ec_clr), .ec_bus_err(be1), .clock_master_select(mcs),
      .out_normalize(onorm), .in_word_bits(iwb), .out_word_bits(owb), .in_format(ifm),
      .out_format(ofm), .port_cfg_undefined(pcu), .download_open(dopen), .mem_wr_valid(wv),
      .mem_wr_sel(wsel), .mem_wr_addr(waddr), .mem_wr_byte(wbyte));
   hcl_dev hcl_dev_i2 (.pclk(pclk), .presetn(presetn), .link(l2), .ext_cfg_present(cfg_pres),
      .boot_done(boot_done), .boot_err(boot_err), .analog_sequence_busy(abusy),
      .ec_bus_err_clr(ec_clr), .ec_bus_err(be2), .clock_master_select(), .out_normalize(),
      .in_word_bits(), .out_word_bits(), .in_format(), .out_format(), .port_cfg_undefined(),
      .download_open(), .mem_wr_valid(), .mem_wr_sel(), .mem_wr_addr(), .mem_wr_byte());
   hcl_host hcl_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(l1));
   hcl_chk hcl_chk_i (.pclk(pclk), .presetn(presetn), .clk(l1.clk), .frame_n(l1.frame_n),
      .mosi(l1.mosi), .mem_wr_valid(wv), .mem_wr_sel(wsel), .download_open(dopen),
      .in_word_bits(iwb), .out_word_bits(owb), .in_format(ifm), .out_format(ofm),
      .port_cfg_undefined(pcu), .clock_master_select(mcs), .out_normalize(onorm));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task automatic wrap_up();
      if (num_errors == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [63:0] s, input logic [63:0] e);
      tests_run++;
      if (s !== e) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic c, input logic [31:0] e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      chk_on <= c;
      if (c) exp_q.push_back(e);
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      pe = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk_on <= 1'b0;
   endtask : apb
   // Host refuses a new command while busy, so poll until idle
   task automatic cmd(input logic [12:0] c, input logic [63:0] d);
      apb(1'b1, HA_WD_HI, d[63:32], 1'b0, 32'h0);
      apb(1'b1, HA_WD_LO, d[31:0], 1'b0, 32'h0);
      apb(1'b1, HA_CTRL, {19'h0, c}, 1'b0, 32'h0);
      do apb(1'b0, HA_STATUS, 32'h0, 1'b0, 32'h0); while (r[0] !== 1'b0);
   endtask : cmd
   task automatic wr(input logic [6:0] s, input logic [3:0] n, input logic [63:0] d);
      cmd({1'b0, n, 1'b0, s}, d);
   endtask : wr
   task automatic rd(input logic [6:0] s, input logic [3:0] n, input logic [63:0] e);
      cmd({1'b0, n, 1'b1, s}, 64'h0);
      apb(1'b0, HA_RD_HI, 32'h0, 1'b1, e[63:32]);
      apb(1'b0, HA_RD_LO, 32'h0, 1'b1, e[31:0]);
   endtask : rd
   task automatic rdst(input logic [7:0] f);
      rd(SUB_STAT, 4'h8, {24'h0, f, 32'h0});
   endtask : rdst
   task automatic load(input logic [7:0] s, input logic good, input logic drop);
      logic [31:0] p;
      logic [15:0] cs;
      p = $random(seed);
      cs = 16'h004A + s + p[31:24] + p[23:16] + p[15:8] + p[7:0];
      wr(SUB_HDR, 4'h8, {cs, s, 8'h00, 16'h1234, 16'h0004});
      if (s <= MEM_SEL_LAST) rdst(8'h01 << s);
      // Payload lands from the header's start address upward
      for (int k = 3; k >= 0; k--) begin
         if (!drop) mem_q.push_back({16'h1234 + 16'(3 - k), 5'h0, s[2:0], p[8*k +: 8]});
      end
      wr(SUB_DATA, 4'h6, {p, good ? cs : ~cs, 16'h0});
   endtask : load
   // Bench-made link; data line flips when released so no stale level lingers
   task automatic frm(input int n, input logic [71:0] d);
      @(posedge pclk);
      l2.frame_n <= 1'b0;
      repeat (4) @(posedge pclk);
      for (int k = 0; k < n; k++) begin
         l2.mosi <= d[71 - k];
         repeat (3) @(posedge pclk);
         l2.clk <= 1'b1;
         repeat (4) @(posedge pclk);
         l2.clk <= 1'b0;
         @(posedge pclk);
      end
      repeat (4) @(posedge pclk);
      l2.frame_n <= 1'b1;
      l2.mosi <= ~l2.mosi;
      repeat (8) @(posedge pclk);
   endtask : frm
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && chk_on) chk(prdata, exp_q.pop_front());
      if (wv === 1'b1) begin
         if (mem_q.size() == 0) chk(1'b1, 1'b0);
         else chk({waddr, 5'h0, wsel, wbyte}, mem_q.pop_front());
      end
      cyc++;
      if (cyc == 90000) begin
         num_errors++;
         wrap_up();
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, chk_on, boot_done, boot_err} = '0;
      {ec_clr, cfg_pres, l2.clk, l2.mosi} = '0;
      abusy = 1'b1;
      l2.frame_n = 1'b1;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      rd(SUB_STAT, 4'h8, {24'h0, 8'hFF, 24'h0, 8'h40});
      boot_err <= 8'($random(seed));
      boot_done <= 1'b1;
      abusy <= 1'b0;
      @(posedge pclk);
      boot_done <= 1'b0;
      rdst(boot_err);
      wr(SUB_STAT, 4'h8, 64'h0);
      rdst(8'h00);
      apb(1'b0, 8'h18, 32'h0, 1'b1, 32'h0);
      chk(pe, 1'b1);
      for (int i = 0; i < 4; i++) begin
         v = ($random(seed) & 32'h0101_0000) | (i << 12) | (i << 8) | (i << 5) | (i << 1);
         wr(SUB_CFG, 4'h4, {v, 32'h0});
         chk(mcs, v[24]);
         chk(onorm, v[16]);
         chk(iwb, i < 3 ? 5'h10 + 5'(4 * i) : 5'h00);
         chk(owb, i < 3 ? 5'h10 + 5'(4 * i) : 5'h00);
         chk({ifm, ofm, pcu}, {v[2:1], v[6:5], i == 3});
         rd(SUB_CFG, 4'h4, {32'h0, v});
      end
      for (int s = 1; s < 5; s++) begin
         load(8'(s), 1'b1, 1'b0);
         rdst(8'h00);
      end
      load(8'h02, 1'b0, 1'b0);
      rdst(8'h04);
      wr(SUB_STAT, 4'h8, 64'h0);
      load(8'h00, 1'b1, 1'b0);
      rdst(8'h00);
      load(8'h00, 1'b1, 1'b1);
      rdst(8'h01);
      wr(SUB_STAT, 4'h8, 64'h0);
      load(8'h05, 1'b1, 1'b1);
      rdst(8'h40);
      wr(SUB_STAT, 4'h8, 64'h0);
      cmd(13'h1000, 64'h0);
      chk(dopen, 1'b0);
      wr(SUB_DATA, 4'h2, 64'h0);
      rdst(8'h80);
      frm(3, 72'h0);
      chk(be2, 1'b1);
      ec_clr <= 1'b1;
      @(posedge pclk);
      ec_clr <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(be2, 1'b0);
      frm(3, 72'h0);
      frm(72, {8'h02, 64'h0});
      chk(be2, 1'b0);
      // Second reset with config memory present; also unlocks controller program
      cfg_pres <= 1'b1;
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      rdst(8'h00);
      load(8'h00, 1'b1, 1'b0);
      rdst(8'h00);
      chk(be1, 1'b0);
      chk(mem_q.size(), 64'h0);
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
